// file: rtl/sew_pkg.sv
// Constants for the serial EEPROM command and watchdog block.
// Assumes a 100 MHz system clock that samples the serial pins.
package sew_pkg;
  localparam int          CLK_MHZ         = 100;
  localparam int          ADDR_W          = 9;
  localparam int          MEM_DEPTH       = 512;
  // Opcodes
  localparam logic [7:0]  OP_SET_LATCH    = 8'h06;
  localparam logic [7:0]  OP_CLR_LATCH    = 8'h04;
  localparam logic [7:0]  OP_READ_STATUS  = 8'h05;
  localparam logic [7:0]  OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0]  OP_READ_MASK    = 8'hf7;
  localparam logic [7:0]  OP_READ         = 8'h03;
  localparam logic [7:0]  OP_WRITE        = 8'h02;
  localparam int          OP_A8_POS       = 3;
  // Status byte fields
  localparam int          ST_BUSY         = 0;
  localparam int          ST_LATCH        = 1;
  localparam int          ST_PROT_LO      = 2;
  localparam int          ST_WDOG_LO      = 4;
  // Protection start addresses
  localparam logic [8:0]  PROT_QUARTER    = 9'h180;
  localparam logic [8:0]  PROT_HALF       = 9'h100;
  // Valid write frame lengths in clocks, watchdog off code, reset values
  localparam logic [5:0]  FRAME_24        = 6'h18;
  localparam logic [5:0]  FRAME_32        = 6'h20;
  localparam logic [5:0]  FRAME_40        = 6'h28;
  localparam logic [5:0]  FRAME_48        = 6'h30;
  localparam logic [5:0]  FRAME_STATUS    = 6'h10;
  localparam logic [1:0]  WDOG_OFF        = 2'h3;
  localparam logic [1:0]  NV_RESET_PROT   = 2'h0;
  localparam logic [1:0]  NV_RESET_WDOG   = 2'h0;
  // Times
  localparam int          WC_MS           = 10;
  localparam int          WDOG_LONG_MS    = 1400;
  localparam int          WDOG_MID_MS     = 600;
  localparam int          WDOG_SHORT_MS   = 200;
  localparam int          WC_CYC          = WC_MS * 1000 * CLK_MHZ;
  localparam int          WDOG_LONG_CYC   = WDOG_LONG_MS * 1000 * CLK_MHZ;
  localparam int          WDOG_MID_CYC    = WDOG_MID_MS * 1000 * CLK_MHZ;
  localparam int          WDOG_SHORT_CYC  = WDOG_SHORT_MS * 1000 * CLK_MHZ;
endpackage

// file: rtl/sew_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
module sew_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  // System
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic             push, pop;

  assign inReady  = (wrPtr_q - rdPtr_q) != (AW+1)'(DEPTH);
  assign outValid = wrPtr_q != rdPtr_q;
  assign outData  = mem[rdPtr_q[AW-1:0]];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    wrPtr_d = wrPtr_q + (AW+1)'(push);
    rdPtr_d = rdPtr_q + (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
    end
    if (push) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end
endmodule

// file: rtl/sew_core.sv
// Serial EEPROM command decoder, write sequencer and watchdog reset.
// Assumes pins are asynchronous to clk; sys_rst stands in for power-up.
//
// Operation
// - Address bit eight comes from opcode bit three.
// - Read streams bytes, address increments, wraps 1FF to 000.
// - Chip select rising ends the read and releases serial output.
// - Read-status opcode shifts out status byte, no address phase.
// - Set-latch opcode not closed by select rise gives no write.
// - One to four bytes per page; address wraps inside page.
// - Write starts only on select rise after clock 24, 32, 40, 48.
// - Status reads during a write show busy bit one, others ones.
// - Low variant drives reset low on supply fault or timeout.
// - High variant drives reset high on same conditions.
// - Decode set latch 06, clear latch 04, read status 05.
// - Decode write status 01, read 0A011, write 0A010.
// - Power-up: standby, output released, write latch clear.
// - No command accepted before a select falling edge after power-up.
// - Write-protect low clears the write latch.
// - Timeout field: 00 1.4 s, 01 600 ms, 10 200 ms, 11 off.
// - Select falling edge restarts watchdog; expiry asserts reset.
// - Status: busy bit 0, latch bit 1, protect 3:2, watchdog 5:4.
// - Protect 01 from 180h, 10 from 100h, 11 all.
module sew_core #(
  parameter bit ACTIVE_HIGH_RST = 1'b0,
  parameter int WC_CYCLES       = sew_pkg::WC_CYC,
  parameter int WDOG_LONG       = sew_pkg::WDOG_LONG_CYC,
  parameter int WDOG_MID        = sew_pkg::WDOG_MID_CYC,
  parameter int WDOG_SHORT      = sew_pkg::WDOG_SHORT_CYC,
  parameter int FIFO_DEPTH      = 8
) (
  // System
  input  wire logic clk,
  input  wire logic sys_rst,
  // Serial pins
  input  wire logic spiSelN,
  input  wire logic spiClk,
  input  wire logic spiIn,
  output logic      spiOut,
  output logic      spiOutEn,
  input  wire logic writeProtN,
  // Supervisor
  input  wire logic supplyLow,
  output logic      resetOut,
  output logic      resetOutEn,
  // Status
  output logic      writeInProgressFlag,
  output logic      writeEnableLatchFlag
);
  timeunit 1ns;
  timeprecision 100ps;
  typedef enum logic [2:0] {
    IDLE = 3'b000, OPC = 3'b001, ADR = 3'b010, RDAT = 3'b011,
    WDAT = 3'b100, STAT = 3'b101, WSTAT = 3'b110, DONE = 3'b111
  } sew_state_type;

  // Pin synchronisers
  logic [1:0] selS_q, clkS_q, inS_q, wpS_q, lowS_q;
  logic       selP_q, clkP_q;
  always_ff @(posedge clk) begin
    selS_q <= {selS_q[0], spiSelN};
    clkS_q <= {clkS_q[0], spiClk};
    inS_q  <= {inS_q[0], spiIn};
    wpS_q  <= {wpS_q[0], writeProtN};
    lowS_q <= {lowS_q[0], supplyLow};
    selP_q <= selS_q[1];
    clkP_q <= clkS_q[1];
  end
  wire selN  = selS_q[1];
  wire selFall = selP_q && !selN;
  wire selRise = !selP_q && selN;
  wire sckRise = !clkP_q && clkS_q[1] && !selN;
  wire sckFall = clkP_q && !clkS_q[1] && !selN;

  function automatic logic protectedAddr(input logic [1:0] lvl, input logic [8:0] a);
    case (lvl)
      2'h1:    protectedAddr = a >= sew_pkg::PROT_QUARTER;
      2'h2:    protectedAddr = a >= sew_pkg::PROT_HALF;
      2'h3:    protectedAddr = 1'b1;
      default: protectedAddr = 1'b0;
    endcase
  endfunction

  logic [7:0]    mem [sew_pkg::MEM_DEPTH];
  sew_state_type st_q, st_d;
  logic [7:0]    sh_q, sh_d, out_q, out_d;
  logic [5:0]    cnt_q, cnt_d;
  logic [8:0]    adr_q, adr_d, pgBase_q, pgBase_d;
  logic          armed_q, armed_d, latch_q, latch_d, busy_q, busy_d;
  logic          oe_q, oe_d, wrOk_q, wrOk_d, isStat_q, isStat_d;
  logic [1:0]    prot_q, prot_d, wdSel_q, wdSel_d, nvPend_q, nvPend_d;
  logic [3:0]    nwb_q, nwb_d;
  logic [31:0]   wc_q, wc_d;
  logic          fifoReady, fifoValid, drain, pushByte;
  logic [16:0]   fifoOut;
  logic [7:0]    bitIn, statusByte;

  assign bitIn = {sh_q[6:0], inS_q[1]};
  // busy status reads as all ones with busy set
  assign statusByte = busy_q ? 8'hff :
    {2'b00, wdSel_q, prot_q, latch_q, busy_q};

  // Write data waits in a FIFO until the cell commit starts
  sew_fifo #(.WIDTH(17), .DEPTH(FIFO_DEPTH)) uFifo (
    .clk(clk), .sys_rst(sys_rst),
    .inValid(pushByte), .inReady(fifoReady), .inData({adr_q, bitIn}),
    .outValid(fifoValid), .outReady(drain), .outData(fifoOut));

  always_comb begin
    st_d     = st_q;
    sh_d     = sh_q;
    out_d    = out_q;
    cnt_d    = cnt_q;
    adr_d    = adr_q;
    pgBase_d = pgBase_q;
    armed_d  = armed_q;
    latch_d  = latch_q;
    busy_d   = busy_q;
    oe_d     = oe_q;
    wrOk_d   = wrOk_q;
    isStat_d = isStat_q;
    prot_d   = prot_q;
    wdSel_d  = wdSel_q;
    nvPend_d = nvPend_q;
    nwb_d    = nwb_q;
    wc_d     = wc_q;
    pushByte = 1'b0;
    drain    = 1'b0;
    // first select fall arms the decoder
    if (selFall) begin
      armed_d = 1'b1;
      st_d = OPC; cnt_d = '0;
    end
    if (sckRise && armed_q && st_q != IDLE) begin
      sh_d = bitIn;
      cnt_d = cnt_q + 6'h1;
      if (cnt_q[2:0] == 3'h7) begin
        case (st_q)
          OPC: begin
            if (bitIn == sew_pkg::OP_SET_LATCH && !busy_q) st_d = DONE;
            else if (bitIn == sew_pkg::OP_CLR_LATCH && !busy_q) begin
              latch_d = 1'b0; st_d = DONE;
            end else if (bitIn == sew_pkg::OP_READ_STATUS) begin
              out_d = statusByte; st_d = STAT;
            end else if (bitIn == sew_pkg::OP_WRITE_STATUS && !busy_q) begin
              st_d = WSTAT; isStat_d = 1'b1; wrOk_d = latch_q;
            end else if ((bitIn & sew_pkg::OP_READ_MASK) == sew_pkg::OP_READ
                         && !busy_q) begin
              // address bit eight from opcode bit three
              adr_d[8] = bitIn[sew_pkg::OP_A8_POS]; st_d = ADR; wrOk_d = 1'b0;
            end else if ((bitIn & sew_pkg::OP_READ_MASK) == sew_pkg::OP_WRITE
                         && !busy_q && latch_q) begin
              adr_d[8] = bitIn[sew_pkg::OP_A8_POS]; st_d = ADR; wrOk_d = 1'b1;
              isStat_d = 1'b0;
            end else st_d = IDLE;
          end
          ADR: begin
            adr_d[7:0] = bitIn;
            if (wrOk_q) begin
              st_d = WDAT; pgBase_d = {adr_q[8], bitIn[7:2], 2'b00}; nwb_d = '0;
            end else begin
              out_d = mem[{adr_q[8], bitIn}]; st_d = RDAT;
              adr_d = {adr_q[8], bitIn} + 9'h1;
            end
          end
          RDAT: begin
            // increment with wrap at top of array
            out_d = mem[adr_q]; adr_d = adr_q + 9'h1;
          end
          STAT: out_d = statusByte;
          WDAT: begin
            // wrap inside the four byte page
            pushByte = fifoReady && !protectedAddr(prot_q, adr_q) && nwb_q < 4'h4;
            if (pushByte) nwb_d = nwb_q + 4'h1;
            adr_d = {pgBase_q[8:2], adr_q[1:0] + 2'h1};
          end
          WSTAT: begin
            nvPend_d = bitIn[3:2]; wdSel_d = wdSel_q;
            prot_d = prot_q; st_d = DONE;
            out_d = bitIn;
            wrOk_d = wrOk_q;
            nwb_d = {bitIn[5:4], 2'b00};
          end
          default: st_d = DONE;
        endcase
      end else if (cnt_q == 6'h0 && st_q == DONE) begin
        // count wrap after the status byte voids the status write
        wrOk_d = 1'b0;
      end
    end
    if (sckFall) oe_d = (st_q == RDAT || st_q == STAT);
    if (selRise) begin
      oe_d = 1'b0;
      st_d = IDLE;
      // set-latch frame must end at exactly eight clocks
      if (st_q == DONE && cnt_q == 6'h8 && sh_q == sew_pkg::OP_SET_LATCH && !busy_q)
        latch_d = 1'b1;
      // write starts only at a whole frame count
      if (st_q == WDAT && wrOk_q && (cnt_q == sew_pkg::FRAME_24 ||
          cnt_q == sew_pkg::FRAME_32 || cnt_q == sew_pkg::FRAME_40 ||
          cnt_q == sew_pkg::FRAME_48)) begin
        busy_d = 1'b1; wc_d = '0;
      end else if (st_q == DONE && isStat_q && wrOk_q && cnt_q == sew_pkg::FRAME_STATUS) begin
        // Status write: protect in 3:2 and watchdog in 5:4
        busy_d = 1'b1; wc_d = '0; prot_d = nvPend_q; wdSel_d = nwb_q[3:2];
      end else if (!busy_q) begin
        nwb_d = '0;
      end
      isStat_d = 1'b0;
    end
    // self-timed cycle commits bytes then clears flags
    if (busy_q) begin
      drain = fifoValid;
      wc_d = wc_q + 32'h1;
      if (wc_q >= 32'(WC_CYCLES - 1)) begin
        busy_d = 1'b0; latch_d = 1'b0; wrOk_d = 1'b0; nwb_d = '0;
      end
    end else if (st_q != WDAT) begin
      // Bytes of an abandoned write are popped and dropped
      drain = fifoValid;
    end
    // write-protect low clears latch and voids pending write
    if (!wpS_q[1]) begin
      latch_d = 1'b0;
      if (!busy_q) wrOk_d = 1'b0;
    end
    if (sckFall && (st_q == RDAT || st_q == STAT) && cnt_q[2:0] != 3'h0)
      out_d = {out_q[6:0], 1'b0};
  end

  // power-up state is standby, output off, latch clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= IDLE; sh_q <= '0; out_q <= '0; cnt_q <= '0; adr_q <= '0;
      pgBase_q <= '0; armed_q <= 1'b0; latch_q <= 1'b0; busy_q <= 1'b0;
      oe_q <= 1'b0; wrOk_q <= 1'b0; isStat_q <= 1'b0;
      prot_q <= sew_pkg::NV_RESET_PROT; wdSel_q <= sew_pkg::NV_RESET_WDOG;
      nvPend_q <= '0; nwb_q <= '0; wc_q <= '0;
    end else begin
      st_q <= st_d; sh_q <= sh_d; out_q <= out_d; cnt_q <= cnt_d; adr_q <= adr_d;
      pgBase_q <= pgBase_d; armed_q <= armed_d; latch_q <= latch_d; busy_q <= busy_d;
      oe_q <= oe_d; wrOk_q <= wrOk_d; isStat_q <= isStat_d; prot_q <= prot_d;
      wdSel_q <= wdSel_d; nvPend_q <= nvPend_d; nwb_q <= nwb_d; wc_q <= wc_d;
    end
    if (drain && busy_q)
      mem[fifoOut[16:8]] <= fifoOut[7:0];
  end

  // Watchdog
  logic [31:0] wd_q, wd_d, wdLimit;
  logic        trip_q, trip_d;
  always_comb begin
    case (wdSel_q)
      2'h0:    wdLimit = 32'(WDOG_LONG);
      2'h1:    wdLimit = 32'(WDOG_MID);
      default: wdLimit = 32'(WDOG_SHORT);
    endcase
    wd_d   = wd_q;
    trip_d = trip_q;
    if (selFall) begin
      wd_d = '0; trip_d = 1'b0;
    end else if (wdSel_q == sew_pkg::WDOG_OFF) begin
      wd_d = '0; trip_d = 1'b0;
    end else if (wd_q >= wdLimit - 32'h1) begin
      trip_d = 1'b1;
    end else begin
      wd_d = wd_q + 32'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wd_q <= '0; trip_q <= 1'b0;
    end else begin
      wd_q <= wd_d; trip_q <= trip_d;
    end
  end

  // active-low variant pulls low on fault
  // active-high variant drives high on fault
  wire fault = trip_q || lowS_q[1];
  assign resetOut   = ACTIVE_HIGH_RST ? 1'b1 : 1'b0;
  assign resetOutEn = fault;
  assign spiOut     = out_q[7];
  assign spiOutEn   = oe_q && !selN;
  assign writeInProgressFlag  = busy_q;
  assign writeEnableLatchFlag = latch_q;
endmodule

// file: verif/sew_core_sva.sv
// Port checker for the serial EEPROM command and watchdog block.
// Assumes one clk domain; bound into every sew_core instance.
module sew_core_sva #(
  parameter bit ACTIVE_HIGH_RST = 1'b0,
  parameter int WC_CYCLES       = 200,
  parameter int WDOG_LONG       = 3000
) (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Serial pins
  input wire logic spiSelN,
  input wire logic spiClk,
  input wire logic spiIn,
  input wire logic spiOut,
  input wire logic spiOutEn,
  input wire logic writeProtN,
  // Supervisor and status
  input wire logic supplyLow,
  input wire logic resetOut,
  input wire logic resetOutEn,
  input wire logic writeInProgressFlag,
  input wire logic writeEnableLatchFlag
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] busyCnt_q, busyCnt_d, idleCnt_q, idleCnt_d;
  logic        selPrev_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Busy length, and time since the last select fall
  always_comb begin
    busyCnt_d = writeInProgressFlag ? busyCnt_q + 32'h1 : 32'h0;
    idleCnt_d = idleCnt_q + {31'h0, idleCnt_q != 32'hffffffff};
    if (selPrev_q && !spiSelN) idleCnt_d = 32'h0;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busyCnt_q <= 32'h0;
      idleCnt_q <= 32'h0;
      selPrev_q <= 1'b1;
    end else begin
      busyCnt_q <= busyCnt_d;
      idleCnt_q <= idleCnt_d;
      selPrev_q <= spiSelN;
    end
  end
  AST_RST_LEVEL: assert property (resetOutEn |-> resetOut == ACTIVE_HIGH_RST)
    else $error("reset output level wrong");
  AST_SUPPLY: assert property (supplyLow [*4] |-> resetOutEn)
    else $error("supply fault without reset");
  AST_OUT_IDLE: assert property (spiSelN [*4] |-> !spiOutEn)
    else $error("serial output driven while deselected");
  AST_OUT_SEL: assert property (spiOutEn |-> !$past(spiSelN, 4))
    else $error("serial output driven without select");
  AST_WP: assert property (!writeProtN [*4] |-> !writeEnableLatchFlag)
    else $error("write latch kept under write protect");
  AST_POWERUP: assert property ($fell(sys_rst) |->
      !spiOutEn && !writeEnableLatchFlag && !writeInProgressFlag)
    else $error("power-up state wrong");
  AST_WRITE_START: assert property ($rose(writeInProgressFlag) |->
      spiSelN && $past(writeEnableLatchFlag))
    else $error("write started without latch or select rise");
  AST_WRITE_END: assert property ($fell(writeInProgressFlag) |->
      ##[0:2] !writeEnableLatchFlag)
    else $error("latch not cleared after write");
  AST_WRITE_TIME: assert property ($fell(writeInProgressFlag) |->
      busyCnt_q >= 32'(WC_CYCLES - 4) && busyCnt_q <= 32'(WC_CYCLES + 4))
    else $error("write cycle length wrong");
  AST_WDOG: assert property (idleCnt_q == 32'(WDOG_LONG + 8) |-> resetOutEn)
    else $error("watchdog did not trip");
endmodule

bind sew_core sew_core_sva #(
  .ACTIVE_HIGH_RST(ACTIVE_HIGH_RST), .WC_CYCLES(WC_CYCLES), .WDOG_LONG(WDOG_LONG)
) checker_i (
  .clk(clk), .sys_rst(sys_rst), .spiSelN(spiSelN), .spiClk(spiClk), .spiIn(spiIn),
  .spiOut(spiOut), .spiOutEn(spiOutEn), .writeProtN(writeProtN),
  .supplyLow(supplyLow), .resetOut(resetOut), .resetOutEn(resetOutEn),
  .writeInProgressFlag(writeInProgressFlag), .writeEnableLatchFlag(writeEnableLatchFlag)
);

// file: verif/sew_host_model.sv
// Host controller model driving the serial pins of the block.
// Assumes clock idles low, 125 ns clock period, bytes MSB first.
module sew_host_model (
  // Serial pins toward the device
  output logic      spiSelN,
  output logic      spiClk,
  output logic      spiIn,
  input  wire logic spiOut,
  input  wire logic spiOutEn
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    spiSelN = 1'b1;
    spiClk  = 1'b0;
    spiIn   = 1'b0;
  end
  // select edges open and close every frame
  task automatic sel(input logic lvl);
    #500;
    spiSelN = lvl;
    #500;
  endtask
  // top n bits of a byte, MSB first; data read only when driven
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      spiIn = tx[i];
      #62.5 spiClk = 1'b1;
      rx[i] = spiOutEn ? spiOut : 1'bx;
      #62.5 spiClk = 1'b0;
    end
  endtask
endmodule

// file: verif/sew_core_test.sv
// Self-checking testbench for the serial EEPROM command block.
// Assumes the host model owns the serial pins; bench owns the rest.
module sew_core_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, sys_rst, writeProtN, supplyLow;
  logic       spiSelN, spiClk, spiIn, spiOut, spiOutEn;
  logic       resetOut, resetOutEn, busy, latch;
  int         nMismatch = 0;
  int         testsRun = 0;
  logic [7:0] rxq[$];
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  sew_host_model hm (.spiSelN(spiSelN), .spiClk(spiClk), .spiIn(spiIn),
    .spiOut(spiOut), .spiOutEn(spiOutEn));
  sew_core #(.WC_CYCLES(1000), .WDOG_LONG(3000)) uut (
    .clk(clk), .sys_rst(sys_rst), .spiSelN(spiSelN), .spiClk(spiClk), .spiIn(spiIn),
    .spiOut(spiOut), .spiOutEn(spiOutEn), .writeProtN(writeProtN),
    .supplyLow(supplyLow), .resetOut(resetOut), .resetOutEn(resetOutEn),
    .writeInProgressFlag(busy), .writeEnableLatchFlag(latch));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp) begin
      nMismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic frame(input logic [7:0] tx[$], input int lastBits);
    logic [7:0] r;
    rxq = {};
    hm.sel(1'b0);
    foreach (tx[i]) begin
      hm.xfer(tx[i], (i == tx.size() - 1) ? lastBits : 8, r);
      rxq.push_back(r);
    end
    hm.sel(1'b1);
  endtask
  task automatic waitIdle();
    int n = 0;
    while (busy !== 1'b0) begin
      @(posedge clk);
      n++;
      if (n > 1500) begin
        nMismatch++;
        summarize();
      end
    end
  endtask
  // Sets the latch, sends a write, judges start and completion
  task automatic wr(input logic [8:0] a, input logic [7:0] d[$], input int lastBits,
                    input logic go);
    frame({sew_pkg::OP_SET_LATCH}, 8);
    frame({sew_pkg::OP_WRITE | {4'h0, a[8], 3'h0}, a[7:0], d}, lastBits);
    chk({7'h0, busy}, {7'h0, go});
    if (go) begin
      frame({sew_pkg::OP_READ_STATUS, 8'h00}, 8);
      chk({7'h0, rxq[1][0]}, 8'h01);
      waitIdle();
      chk({6'h0, busy, latch}, 8'h00);
    end
  endtask
  task automatic rd(input logic [8:0] a, input int n);
    logic [7:0] q[$];
    q = {sew_pkg::OP_READ | {4'h0, a[8], 3'h0}, a[7:0]};
    repeat (n) q.push_back(8'h00);
    frame(q, 8);
  endtask
  task automatic tLatch();
    chk({6'h0, spiOutEn, latch}, 8'h00);
    frame({sew_pkg::OP_SET_LATCH}, 8);
    chk({7'h0, latch}, 8'h01);
    frame({sew_pkg::OP_READ_STATUS, 8'h00}, 8);
    chk(rxq[1] & 8'h3f, 8'h02);
    frame({sew_pkg::OP_CLR_LATCH}, 8);
    chk({7'h0, latch}, 8'h00);
    frame({sew_pkg::OP_SET_LATCH}, 8);
    @(posedge clk) writeProtN <= 1'b0;
    repeat (8) @(posedge clk);
    writeProtN <= 1'b1;
    chk({7'h0, latch}, 8'h00);
    $display("done: latch and status");
  endtask
  task automatic tWrite();
    logic [7:0] d[$];
    wr(9'h000, {8'h5a}, 8, 1'b1);
    for (int n = 2; n <= 4; n++) begin
      d = {};
      for (int i = 0; i < n; i++) d.push_back(8'(8'h20 + n * 8 + i));
      wr(9'(n * 4), d, 8, 1'b1);
      rd(9'(n * 4), n);
      foreach (d[i]) chk(rxq[2 + i], d[i]);
    end
    wr(9'h1fe, {8'hc1, 8'hc2, 8'hc3}, 8, 1'b1);
    rd(9'h1fc, 5);
    chk(rxq[2], 8'hc3);
    chk(rxq[4], 8'hc1);
    chk(rxq[6], 8'h5a);
    $display("done: writes and reads");
  endtask
  task automatic tRefused();
    frame({sew_pkg::OP_SET_LATCH, sew_pkg::OP_WRITE, 8'h00, 8'ha5}, 8);
    chk({6'h0, busy, latch}, 8'h00);
    wr(9'h000, {8'ha5, 8'ha5}, 4, 1'b0);
    frame({sew_pkg::OP_CLR_LATCH}, 8);
    frame({sew_pkg::OP_WRITE, 8'h00, 8'ha5}, 8);
    waitIdle();
    rd(9'h000, 1);
    chk(rxq[2], 8'h5a);
    $display("done: refused writes");
  endtask
  task automatic tProtect();
    frame({sew_pkg::OP_SET_LATCH}, 8);
    frame({sew_pkg::OP_WRITE_STATUS, 8'h04}, 8);
    waitIdle();
    frame({sew_pkg::OP_READ_STATUS, 8'h00}, 8);
    chk(rxq[1] & 8'h3f, 8'h04);
    frame({sew_pkg::OP_SET_LATCH}, 8);
    frame({8'h0a, 8'hfe, 8'h77}, 8);
    waitIdle();
    wr(9'h17f, {8'h3c}, 8, 1'b1);
    rd(9'h17f, 130);
    chk(rxq[2], 8'h3c);
    chk(rxq[129], 8'hc1);
    chk(rxq[131], 8'h5a);
    $display("done: protection");
  endtask
  task automatic tSupervisor();
    int n = 0;
    hm.sel(1'b0);
    hm.sel(1'b1);
    repeat (2800) @(posedge clk);
    chk({7'h0, resetOutEn}, 8'h00);
    while (resetOutEn !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk({6'h0, resetOutEn, resetOut}, 8'h02);
    hm.sel(1'b0);
    hm.sel(1'b1);
    chk({7'h0, resetOutEn}, 8'h00);
    @(posedge clk) supplyLow <= 1'b1;
    repeat (6) @(posedge clk);
    chk({6'h0, resetOutEn, resetOut}, 8'h02);
    supplyLow <= 1'b0;
    repeat (6) @(posedge clk);
    chk({7'h0, resetOutEn}, 8'h00);
    $display("done: watchdog and supply");
  endtask
  initial begin
    sys_rst = 1'b1;
    writeProtN = 1'b1;
    supplyLow = 1'b0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    tLatch();
    tWrite();
    tRefused();
    tProtect();
    tSupervisor();
    summarize();
  end
endmodule
